/* File: core/pscd_pkg.sv */
// Package: register map, field layout, reset values and timing for the port scan config block
// Functional notes
// R1 - Transmit level code bits 3:0; 0x0 is -0.5dBm, each step adds 0.5dB.
// R2 - Transmit level code resets to 0x7, nominal 3.0dBm.
// R3 - Code 0xD is the highest recommended level, 6.0dBm.
// R4 - Codes 0xE and 0xF are stored as written; output may clip.
// R5 - Dwell multiplier bits 11:8 sit in scan config bits 7:4, RW, reset zero.
// R6 - Dwell bits 7:0 sit in their own RW register; multiplier counts bit periods.
// R7 - Low dwell byte resets to 0x52, 82 bit periods, one probe frame.
// R8 - Cleared include bit makes the scan skip that RF port.
// R9 - Set include bit makes the scan visit the port; all reset to one.
// R10 - User dwell multiplier governs dwell only when hold select equals 0x3.
// R11 - Dwell counter reloads from current multiplier on each move to a new port.
package pscd_pkg;
    // ------------------------------------------------------------
    // Register word indexes, decoded from paddr bits 5:2 (printed offsets not all multiples of four)
    // ------------------------------------------------------------
    localparam logic [3:0] PSCD_IDX_LEVEL = 4'h3;
    localparam logic [3:0] PSCD_IDX_SCAN_CFG = 4'h4;
    localparam logic [3:0] PSCD_IDX_DWELL_LOW = 4'h5;
    localparam logic [3:0] PSCD_IDX_SCAN_CTRL = 4'h2;
    localparam logic [3:0] PSCD_IDX_SCAN_STAT = 4'h6;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] PSCD_LEVEL_RST = 4'h7;
    localparam logic [3:0] PSCD_LEVEL_CEIL = 4'hd;
    localparam logic [3:0] PSCD_DWELL_HIGH_RST = 4'h0;
    localparam logic [7:0] PSCD_DWELL_LOW_RST = 8'h52;
    localparam logic [3:0] PSCD_INCLUDE_RST = 4'hf;
    localparam logic [1:0] PSCD_HOLD_RST = 2'h1;
    localparam logic [1:0] PSCD_HOLD_USER = 2'h3;
    localparam logic [1:0] PSCD_HOLD_ONE = 2'h1;
    localparam logic [1:0] PSCD_HOLD_SIXTEEN = 2'h2;
    localparam logic [1:0] PSCD_HOLD_MANUAL = 2'h0;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PSCD_LEVEL_LSB = 0;
    localparam int PSCD_INCLUDE_LSB = 0;
    localparam int PSCD_DWELL_HIGH_LSB = 4;
    localparam int PSCD_HOLD_LSB = 4;
    localparam int PSCD_START_BIT = 0;
    localparam int PSCD_STEP_BIT = 1;
    // ------------------------------------------------------------
    // Timing: bit period at the default link rate
    // ------------------------------------------------------------
    localparam int PSCD_CLK_HZ = 40000000;
    localparam int PSCD_BIT_RATE_BPS = 9600;
    localparam int PSCD_BIT_CYCLES = PSCD_CLK_HZ / PSCD_BIT_RATE_BPS;
    localparam logic [11:0] PSCD_SIXTEEN_BITS = 12'h010;
    localparam logic [11:0] PSCD_ONE_BIT = 12'h001;

    typedef struct packed {
        logic [3:0] tx_level_code;
        logic [3:0] port_include;
        logic [11:0] dwell_multiplier_low;
        logic [1:0] hold_sel;
    } pscd_cfg_t;

    typedef struct packed {
        logic scanning;
        logic [1:0] port;
    } pscd_scan_t;
endpackage

/* File: core/pscd_top.sv */
// Module: APB register bank and port scan sequencer for dwell and transmit level
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module pscd_top #(
    parameter int BIT_CYCLES = pscd_pkg::PSCD_BIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [3:0] tx_level_code,
    output logic [1:0] scan_port,
    output logic scan_active
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic setup = psel && !penable;
    wire logic acc = psel && penable;
    wire logic aligned = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
    wire logic [3:0] idx = paddr[5:2];
    wire logic hit_level = aligned && idx == pscd_pkg::PSCD_IDX_LEVEL;
    wire logic hit_cfg = aligned && idx == pscd_pkg::PSCD_IDX_SCAN_CFG;
    wire logic hit_low = aligned && idx == pscd_pkg::PSCD_IDX_DWELL_LOW;
    wire logic hit_ctrl = aligned && idx == pscd_pkg::PSCD_IDX_SCAN_CTRL;
    wire logic hit_stat = aligned && idx == pscd_pkg::PSCD_IDX_SCAN_STAT;
    wire logic hit_any = hit_level || hit_cfg || hit_low || hit_ctrl || hit_stat;
    // Write lands once, at the edge that ends the access phase: access with pready to a mapped address
    wire logic wr = acc && pready && pwrite && hit_any;

    logic [3:0] level_reg;
    logic [3:0] include_reg;
    logic [3:0] dwell_high_reg;
    logic [7:0] dwell_low_reg;
    logic [1:0] hold_reg;
    logic start_reg;
    logic step_reg;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Every code 0x0..0xf is stored unfiltered; 0xe/0xf may clip the output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= pscd_pkg::PSCD_LEVEL_RST; // R2
            include_reg <= pscd_pkg::PSCD_INCLUDE_RST; // R9
            dwell_high_reg <= pscd_pkg::PSCD_DWELL_HIGH_RST; // R5
            dwell_low_reg <= pscd_pkg::PSCD_DWELL_LOW_RST; // R7
            hold_reg <= pscd_pkg::PSCD_HOLD_RST;
        end else if (wr) begin
            if (hit_level) begin
                level_reg <= pwdata[pscd_pkg::PSCD_LEVEL_LSB +: 4]; // R1 R3 R4
            end
            if (hit_cfg) begin
                dwell_high_reg <= pwdata[pscd_pkg::PSCD_DWELL_HIGH_LSB +: 4]; // R5
                include_reg <= pwdata[pscd_pkg::PSCD_INCLUDE_LSB +: 4]; // R8 R9
            end
            if (hit_low) begin
                dwell_low_reg <= pwdata[7:0]; // R6
            end
            if (hit_ctrl) begin
                hold_reg <= pwdata[pscd_pkg::PSCD_HOLD_LSB +: 2];
            end
        end
    end

    // Start and manual step are self-clearing one-cycle pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_reg <= 1'b0;
            step_reg <= 1'b0;
        end else begin
            start_reg <= wr && hit_ctrl && pwdata[pscd_pkg::PSCD_START_BIT];
            step_reg <= wr && hit_ctrl && pwdata[pscd_pkg::PSCD_STEP_BIT];
        end
    end

    pscd_pkg::pscd_cfg_t cfg;
    assign cfg.tx_level_code = level_reg;
    assign cfg.port_include = include_reg;
    assign cfg.dwell_multiplier_low = {dwell_high_reg, dwell_low_reg}; // R6
    assign cfg.hold_sel = hold_reg;

    // ------------------------------------------------------------
    // Bit period enable
    // ------------------------------------------------------------
    logic [15:0] div_reg;
    wire logic bit_tick = div_reg == 16'(BIT_CYCLES - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 16'h0000;
        end else if (bit_tick || !scan_active) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Scan sequencer
    // ------------------------------------------------------------
    // Dwell in bit periods chosen by the hold select field
    wire logic [11:0] dwell_len = (cfg.hold_sel == pscd_pkg::PSCD_HOLD_USER) ? cfg.dwell_multiplier_low : // R10
        (cfg.hold_sel == pscd_pkg::PSCD_HOLD_SIXTEEN) ? pscd_pkg::PSCD_SIXTEEN_BITS : pscd_pkg::PSCD_ONE_BIT;
    wire logic manual = cfg.hold_sel == pscd_pkg::PSCD_HOLD_MANUAL;

    // Next included port after the current one, wrapping; current kept if none other
    logic [1:0] next_port;
    logic found;
    always_comb begin
        next_port = scan_port;
        found = 1'b0;
        for (int k = 1; k <= 4; k++) begin
            if (!found && cfg.port_include[2'(scan_port + 2'(k))]) begin // R8 R9
                next_port = 2'(scan_port + 2'(k));
                found = 1'b1;
            end
        end
    end

    logic [1:0] first_port;
    always_comb begin
        first_port = 2'h0;
        for (int k = 3; k >= 0; k--) begin
            if (cfg.port_include[k]) begin
                first_port = 2'(k);
            end
        end
    end

    typedef enum logic [0:0] {
        PSCD_IDLE = 1'b0,
        PSCD_DWELL = 1'b1
    } pscd_state_t;
    pscd_state_t state_reg;
    logic [11:0] cnt_reg;

    // Zero multiplier in user mode is treated as one bit period
    wire logic dwell_done = bit_tick && (cnt_reg <= 12'h001);
    wire logic advance = manual ? step_reg : dwell_done;
    // A scan with every port excluded never starts
    wire logic can_start = start_reg && (cfg.port_include != 4'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PSCD_IDLE;
            scan_port <= 2'h0;
            scan_active <= 1'b0;
            cnt_reg <= 12'h000;
        end else begin
            unique case (state_reg)
                PSCD_IDLE: begin
                    if (can_start) begin
                        state_reg <= PSCD_DWELL;
                        scan_active <= 1'b1;
                        scan_port <= first_port;
                        cnt_reg <= dwell_len; // R11
                    end
                end
                PSCD_DWELL: begin
                    if (cfg.port_include == 4'h0) begin
                        state_reg <= PSCD_IDLE;
                        scan_active <= 1'b0;
                    end else if (advance) begin
                        scan_port <= next_port; // R8 R9
                        cnt_reg <= dwell_len; // R11
                    end else if (bit_tick && cnt_reg != 12'h000) begin
                        cnt_reg <= cnt_reg - 12'h001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_level_code <= pscd_pkg::PSCD_LEVEL_RST; // R2
        end else begin
            tx_level_code <= cfg.tx_level_code; // R1 R4
        end
    end

    // ------------------------------------------------------------
    // Read data and answer
    // ------------------------------------------------------------
    // Zero wait states: pready rises in every access phase
    wire logic [31:0] rd_mux = hit_level ? {28'h0, level_reg} :
        hit_cfg ? {24'h0, dwell_high_reg, include_reg} :
        hit_low ? {24'h0, dwell_low_reg} :
        hit_ctrl ? {26'h0, hold_reg, 4'h0} :
        hit_stat ? {29'h0, scan_active, scan_port} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit_any;
            prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    level_rst_a: assert property (@(posedge pclk) $rose(presetn) |-> level_reg == 4'h7) // R2
        else $error("level code not 0x7 after reset");
    level_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
        wr && hit_level |=> level_reg == $past(pwdata[3:0]))
        else $error("level code not stored as written");
    level_out_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
        ##1 tx_level_code == $past(level_reg))
        else $error("level output lags wrongly");
    low_rst_a: assert property (@(posedge pclk) $rose(presetn) |-> dwell_low_reg == 8'h52) // R7
        else $error("dwell low not 0x52 after reset");
    high_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
        wr && hit_cfg |=> dwell_high_reg == $past(pwdata[7:4]))
        else $error("dwell high nibble not stored");
    low_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
        wr && hit_low |=> cfg.dwell_multiplier_low[7:0] == $past(pwdata[7:0]))
        else $error("dwell low byte not stored");
    skip_port_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
        state_reg == PSCD_DWELL && advance && include_reg != 4'h0 |-> include_reg[next_port])
        else $error("scan moving to excluded port");
    include_rst_a: assert property (@(posedge pclk) $rose(presetn) |-> include_reg == 4'hf) // R9
        else $error("include bits not all set after reset");
    user_dwell_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        hold_reg == 2'h3 |-> dwell_len == {dwell_high_reg, dwell_low_reg})
        else $error("user dwell not selected");
    reload_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        state_reg == PSCD_DWELL && advance && include_reg != 4'h0 |=> cnt_reg == $past(dwell_len))
        else $error("dwell counter not reloaded");

    // ------------------------------------------------------------
    // Bus answer checks
    // ------------------------------------------------------------
    // Zero wait states are part of the contract, so any stretch is a fault
    ready_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held too long");
    err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !hit_any |=> pslverr)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && hit_any |=> !pslverr)
        else $error("mapped access refused");
    err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0)
        else $error("read data outside access");
    rdata_level_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
        setup && !pwrite && hit_level |=> prdata == {28'h0, $past(level_reg)})
        else $error("level read data wrong");
    rdata_cfg_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
        setup && !pwrite && hit_cfg |=> prdata == {24'h0, $past(dwell_high_reg), $past(include_reg)})
        else $error("scan config read data wrong");
    rdata_low_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
        setup && !pwrite && hit_low |=> prdata == {24'h0, $past(dwell_low_reg)})
        else $error("dwell low read data wrong");
    refused_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && pready && pwrite && !hit_any |=> $stable(level_reg) && $stable(include_reg) &&
        $stable(dwell_high_reg) && $stable(dwell_low_reg) && $stable(hold_reg))
        else $error("refused write changed a register");

    // ------------------------------------------------------------
    // Register checks
    // ------------------------------------------------------------
    level_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
        !(wr && hit_level) |=> $stable(level_reg))
        else $error("level code changed without write");
    cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
        !(wr && hit_cfg) |=> $stable(include_reg) && $stable(dwell_high_reg))
        else $error("scan config changed without write");
    low_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
        !(wr && hit_low) |=> $stable(dwell_low_reg))
        else $error("dwell low changed without write");
    include_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
        wr && hit_cfg |=> include_reg == $past(pwdata[3:0]))
        else $error("include bits not stored");
    hold_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        wr && hit_ctrl |=> hold_reg == $past(pwdata[5:4]))
        else $error("hold select not stored");
    high_rst_a: assert property (@(posedge pclk) $rose(presetn) |-> dwell_high_reg == 4'h0) // R5
        else $error("dwell high not zero after reset");
    out_rst_a: assert property (@(posedge pclk) $rose(presetn) |-> tx_level_code == 4'h7) // R2
        else $error("level output not 0x7 after reset");
    hold_rst_a: assert property (@(posedge pclk) $rose(presetn) |-> hold_reg == 2'h1)
        else $error("hold select not one after reset");
    start_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_reg |=> !start_reg)
        else $error("start pulse too long");
    step_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        step_reg |=> !step_reg)
        else $error("step pulse too long");

    // ------------------------------------------------------------
    // Scan checks
    // ------------------------------------------------------------
    // The scan flag and the state must never disagree, or reads lie
    idle_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        !scan_active |-> state_reg == PSCD_IDLE)
        else $error("scan flag and state disagree");
    stop_empty_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
        scan_active && include_reg == 4'h0 |=> !scan_active)
        else $error("scan kept running with no port");
    start_first_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
        state_reg == PSCD_IDLE && can_start |=> scan_active && scan_port == $past(first_port))
        else $error("scan did not start on first port");
    start_empty_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
        state_reg == PSCD_IDLE && start_reg && include_reg == 4'h0 |=> !scan_active)
        else $error("scan started with no port");
    one_bit_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        hold_reg == 2'h1 |-> dwell_len == 12'h001)
        else $error("one bit dwell not selected");
    sixteen_bit_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        hold_reg == 2'h2 |-> dwell_len == 12'h010)
        else $error("sixteen bit dwell not selected");
    manual_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        scan_active && manual && !step_reg && include_reg != 4'h0 |=> $stable(scan_port))
        else $error("manual scan moved without step");
    count_down_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        state_reg == PSCD_DWELL && !advance && bit_tick && cnt_reg != 12'h000 && include_reg != 4'h0
        |=> cnt_reg == $past(cnt_reg) - 12'h001)
        else $error("dwell counter not counting down");
    count_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        state_reg == PSCD_DWELL && !advance && !bit_tick && include_reg != 4'h0 |=> $stable(cnt_reg))
        else $error("dwell counter moved between ticks");
    div_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !scan_active |=> div_reg == 16'h0000)
        else $error("bit divider runs while idle");
endmodule

/* File: sim/port_scan_dwell_and_tx_level_config_test.sv */
// Testbench: APB register checks and scan sequencing for the port scan config block
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module port_scan_dwell_and_tx_level_config_test;
    // ------------------------------------------------------------
    // Clock, reset and design
    // ------------------------------------------------------------
    localparam int BC = 4; // Short bit period keeps the run brief
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] tx_level_code;
    logic [1:0] scan_port;
    logic scan_active;
    logic [31:0] rd;
    logic er;
    logic [1:0] p;
    logic [1:0] q;
    int err_count = 0;
    int checked = 0;
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    pscd_top #(.BIT_CYCLES(BC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_level_code(tx_level_code), .scan_port(scan_port), .scan_active(scan_active));
    // ------------------------------------------------------------
    // Bus and scan helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        er = pslverr;
        if (n >= 100) `CHK(pready, 1'b1)
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        apb(1'b0, a, 32'h0);
        `CHK(rd, exp)
        `CHK(er, eexp)
    endtask
    // Waits for the next change of the scanned port; bounded so a stuck scan is seen
    task automatic nextp(output int n);
        logic [1:0] q;
        q = scan_port;
        n = 0;
        while (scan_port === q && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        p = scan_port;
    endtask
    // Skips the dwell in progress, then measures one whole dwell
    task automatic gap(input int exp);
        int n;
        nextp(n);
        nextp(n);
        `CHK(n, exp)
    endtask
    task automatic results;
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        int n;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(tx_level_code, 4'h7)
        rchk(8'h0c, 32'h7, 1'b0);
        rchk(8'h10, 32'h0f, 1'b0);
        rchk(8'h14, 32'h52, 1'b0);
        rchk(8'h08, 32'h10, 1'b0);
        rchk(8'h18, 32'h0, 1'b0);
        // Every level code, clipping codes included, is stored and driven out
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 8'h0c, 32'hffffff00 | i);
            @(posedge pclk);
            `CHK(tx_level_code, 4'(i))
            rchk(8'h0c, 32'(i), 1'b0);
        end
        // Unmapped and misaligned places refuse, and the misaligned write leaves the level register alone
        apb(1'b1, 8'h20, 32'h0);
        `CHK(er, 1'b1)
        apb(1'b1, 8'h0d, 32'h3);
        `CHK(er, 1'b1)
        rchk(8'h0c, 32'hf, 1'b0);
        rchk(8'h1c, 32'h0, 1'b1);
        // Ports 1 and 3 included, user multiplier of 2 bit periods
        apb(1'b1, 8'h10, 32'h0a);
        apb(1'b1, 8'h14, 32'h02);
        rchk(8'h10, 32'h0a, 1'b0);
        rchk(8'h14, 32'h02, 1'b0);
        apb(1'b1, 8'h08, 32'h31);
        nextp(n);
        `CHK(p, 2'h1)
        `CHK(scan_active, 1'b1)
        nextp(n);
        `CHK(p, 2'h3)
        nextp(n);
        `CHK(p, 2'h1)
        gap(2 * BC);
        apb(1'b1, 8'h14, 32'h03);
        gap(3 * BC);
        apb(1'b1, 8'h08, 32'h10);
        gap(BC);
        apb(1'b1, 8'h08, 32'h20);
        gap(16 * BC);
        apb(1'b1, 8'h08, 32'h30);
        apb(1'b1, 8'h10, 32'h1a);
        apb(1'b1, 8'h14, 32'h00);
        gap(256 * BC);
        // Manual hold: the port moves only on a step request
        apb(1'b1, 8'h08, 32'h00);
        repeat (20) @(posedge pclk);
        p = scan_port;
        repeat (20) @(posedge pclk);
        `CHK(scan_port, p)
        q = p;
        apb(1'b1, 8'h08, 32'h02);
        nextp(n);
        `CHK(p, (q == 2'h1) ? 2'h3 : 2'h1)
        `CHK(n < 10, 1'b1)
        // No port left included: the scan ends
        apb(1'b1, 8'h10, 32'h10);
        apb(1'b1, 8'h08, 32'h11);
        n = 0;
        while (scan_active !== 1'b0 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        `CHK(scan_active, 1'b0)
        results();
    end
    // ------------------------------------------------------------
    // Watchdog, well beyond the expected run length
    // ------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        results();
    end
endmodule
